// ===== pwpet_accept.sv
// acceptance stage: edge or level detect, set/reset latch, termination
// assumes inputs already in the aclk domain
module pwpet_accept (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       src_in,
	input  wire logic       acc_qual,
	input  wire logic       term_hit,
	input  wire logic [2:0] acceptance_criteria,
	input  wire logic       latch_rdom,
	output logic            active
);
	import pwpet_pkg::*;

	logic q;
	logic prev;
	logic rise;
	logic any_edge;
	logic set_in;
	logic latched;
	logic next_latched;
	logic next_active;
	logic is_latched;

	// ----------------------------------------
	// edge detect against last cycle
	// ----------------------------------------
	assign q        = src_in & acc_qual;
	assign rise     = q & ~prev;                                 // R24
	assign any_edge = q ^ prev;                                  // R24
	assign is_latched = (acceptance_criteria == ACP_LATCH) || (acceptance_criteria == ACP_LATCH_RISE) ||
		(acceptance_criteria == ACP_LATCH_ANY);
	assign set_in   = (acceptance_criteria == ACP_LATCH_RISE) ? rise :
		(acceptance_criteria == ACP_LATCH_ANY) ? any_edge : q;                   // R04

	// ----------------------------------------
	// latch dominance
	// ----------------------------------------
	// reset-dominant drops a set that meets a termination
	assign next_latched = latch_rdom ? (~term_hit & (set_in | latched)) :
		(set_in | (latched & ~term_hit));                        // R07

	// codes 6 and 7 keep the output low
	assign next_active = (acceptance_criteria == ACP_LEVEL) ? q :
		(acceptance_criteria == ACP_RISE) ? rise :
		(acceptance_criteria == ACP_ANY) ? any_edge :
		is_latched ? next_latched : 1'b0;                        // R04

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev    <= 1'b0;
			latched <= 1'b0;
			active  <= 1'b0;
		end else begin
			prev    <= q;
			latched <= is_latched ? next_latched : 1'b0;
			active  <= next_active;
		end
	end

endmodule

// ===== pwpet_far.sv
// far-side model: adc trigger inputs and cpu interrupt controller
// assumes one-cycle active-high pulses on aclk; it never stalls
module pwpet_far (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic adc_trig1,
	input wire logic adc_trig2,
	input wire logic cpu_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	int n1 = 0, n2 = 0, ni = 0;
	// each pulse is one conversion start or one interrupt request
	always @(posedge aclk) begin
		n1 <= aresetn ? n1 + adc_trig1 : 0;
		n2 <= aresetn ? n2 + adc_trig2 : 0;
		ni <= aresetn ? ni + cpu_irq : 0;
	end
endmodule

// ===== pwpet_pkg.sv
// constants of the pwm protective-input and event block
// assumes one 40 MHz clock and a 32-bit axi4-lite register port
package pwpet_pkg;

	// ----------------------------------------
	// bus and register map
	// ----------------------------------------
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam logic [7:0]  OFS_PCI_HIGH = 8'h00;
	localparam logic [7:0]  OFS_EVT_LOW  = 8'h04;
	localparam logic [7:0]  OFS_EVT_HIGH = 8'h08;
	localparam logic [7:0]  OFS_STATUS   = 8'h0C;
	localparam logic [7:0]  OFS_CONFIG   = 8'h10;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ----------------------------------------
	// reset values and writable bits
	// ----------------------------------------
	localparam logic [15:0] RST_PCI_HIGH  = 16'h0000;
	localparam logic [15:0] RST_EVT_LOW   = 16'h0000;
	localparam logic [15:0] RST_EVT_HIGH  = 16'h0000;
	localparam logic [15:0] RST_CONFIG    = 16'h0000;
	localparam logic [15:0] MASK_PCI_HIGH = 16'hF7FF;
	localparam logic [15:0] MASK_EVT_LOW  = 16'hFF1F;
	localparam logic [15:0] MASK_EVT_HIGH = 16'hF3FF;
	localparam logic [15:0] MASK_CONFIG   = 16'h071F;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int POS_BYPASS_ENABLE   = 15;
	localparam int POS_BYPASS_SOURCE_SEL  = 12;
	localparam int POS_ACP    = 8;
	localparam int POS_SOFTWARE_PROTECT_BIT  = 7;
	localparam int POS_SWMODE = 5;
	localparam int POS_LATCH_DOMINANCE = 4;
	localparam int POS_TERM_QUAL_POLARITY   = 3;
	localparam int POS_TERM_QUAL_SOURCE   = 0;
	localparam int POS_PS     = 11;
	localparam int POS_EN1    = 8;
	localparam int POS_UPD    = 3;
	localparam int POS_TRGSEL = 0;
	localparam int POS_IEN    = 12;
	localparam int POS_IEVT   = 8;
	localparam int POS_EN2    = 5;
	localparam int POS_OFS    = 0;
	localparam int POS_UREQ   = 0;
	localparam int POS_ACTIVE = 1;
	localparam int POS_SRC    = 0;
	localparam int POS_MUX    = 8;

	// ----------------------------------------
	// field codes
	// ----------------------------------------
	localparam logic [2:0] ACP_LEVEL      = 3'h0;
	localparam logic [2:0] ACP_RISE       = 3'h1;
	localparam logic [2:0] ACP_ANY        = 3'h2;
	localparam logic [2:0] ACP_LATCH      = 3'h3;
	localparam logic [2:0] ACP_LATCH_RISE = 3'h4;
	localparam logic [2:0] ACP_LATCH_ANY  = 3'h5;
	localparam logic [1:0] SWM_ACCEPT     = 2'h0;
	localparam logic [1:0] SWM_AQUAL      = 2'h1;
	localparam logic [1:0] SWM_TQUAL      = 2'h2;
	localparam logic [1:0] UPD_DUTY       = 2'h1;
	localparam logic [1:0] UPD_PHASE      = 2'h2;
	localparam logic [1:0] UPD_CMPA       = 2'h3;
	localparam logic [2:0] TRG_EOC        = 3'h0;
	localparam logic [2:0] TRG_CMPA       = 3'h1;
	localparam logic [2:0] TRG_CMPB       = 3'h2;
	localparam logic [2:0] TRG_CMPC       = 3'h3;
	localparam logic [1:0] IEV_EOC        = 2'h0;
	localparam logic [1:0] IEV_CMPA       = 2'h1;
	localparam logic [1:0] IEV_ADC1       = 2'h2;
	localparam logic [7:0] GEN_PRESENT    = 8'hFF;
	localparam int         EXT_W          = 20;

endpackage

// ===== pwpet_props.sv
// port checker for pwpet_top, bound below
// assumes one aclk domain with synchronous active-low reset
module pwpet_props (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       compare_a,
	input wire logic       compare_b,
	input wire logic       compare_c,
	input wire logic       eoc_event,
	input wire logic [3:0] prot_active,
	input wire logic       duty_write,
	input wire logic       phase_write,
	input wire logic       cmpa_write,
	input wire logic       update_taken,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       adc_trig1,
	input wire logic       adc_trig2,
	input wire logic       gen_trigger,
	input wire logic       cpu_irq,
	input wire logic       update_request
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire cmp_any = compare_a | compare_b | compare_c;
	property p_trig1; adc_trig1 |-> $past(cmp_any); endproperty
	a_trig1: assert property (p_trig1) else $error("trig1 without compare");
	property p_trig2; adc_trig2 |-> $past(cmp_any); endproperty
	a_trig2: assert property (p_trig2) else $error("trig2 without compare");
	property p_gen; gen_trigger |-> $past(cmp_any | eoc_event); endproperty
	a_gen: assert property (p_gen) else $error("gen trigger without event");
	property p_irq; cpu_irq |-> $past(cmp_any | eoc_event | (|prot_active)); endproperty
	a_irq: assert property (p_irq) else $error("irq without cause");
	property p_set; $rose(update_request) |-> $past(duty_write | phase_write | cmpa_write)
		|| $rose(s_axi_bvalid); endproperty
	a_set: assert property (p_set) else $error("update set without write");
	property p_hold; update_request && !update_taken |=> update_request; endproperty
	a_hold: assert property (p_hold) else $error("update lost");
	property p_clr; $fell(update_request) |-> $past(update_taken); endproperty
	a_clr: assert property (p_clr) else $error("update cleared alone");
	property p_b; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_b: assert property (p_b) else $error("bvalid dropped early");
endmodule
bind pwpet_top pwpet_props i_props (.*);

// ===== pwpet_top.sv
// pwm generator protective-input conditioning, adc triggers, irq select
// assumes axi4-lite master on aclk; pins and remap inputs asynchronous
//
// What this block does
// R01: bypass enable takes another generator's protection
// R02: bypass field picks generator one to eight
// R03: absent generator selection reads as zero
// R04: acceptance codes: level, edges, latched variants
// R05: software bit drives its value into logic
// R06: software mode picks acceptance, qualifier, termination
// R07: latch mode bit selects reset or set dominance
// R08: polarity bit inverts termination qualifier
// R09: qualifier code 000 forces one, 111 zero
// R10: qualifier codes pick duty, blanking, trigger, sources
// R11: trigger one postscaled one per N+1 events
// R12: compare A, B, C each enable trigger one
// R13: separate compare enables for trigger two
// R14: update request set by chosen register write
// R15: code 00 leaves update request to software
// R16: generator trigger picks cycle end or compare
// R17: each protective interrupt has own enable
// R18: protective interrupts fire on rising edge only
// R19: event select picks cycle end, compare A, trigger
// R20: code 11 silences time-base interrupts only
// R21: low source codes pick combos, mux, zero
// R22: higher codes pick remap, pins, events, comparators
// R23: offset delays trigger one by 0..31 events
// R24: edges compare against previous clock value
module pwpet_top (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [pwpet_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [pwpet_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [pwpet_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [pwpet_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic [10:0]                   remap_in,
	input  wire logic [3:0]                    pin_in,
	input  wire logic [3:0]                    comparator_in,
	input  wire logic                          logic_cell_one,
	input  wire logic [3:0]                    other_core_evt,
	input  wire logic                          combo_trig_a,
	input  wire logic                          combo_trig_b,
	input  wire logic [7:0]                    gen_out,
	input  wire logic [7:0]                    other_gen_pci,
	input  wire logic                          pci_src8,
	input  wire logic                          pci_src9,
	input  wire logic                          duty_active,
	input  wire logic                          blanking_active,
	input  wire logic                          gen_triggered,
	input  wire logic                          term_event,
	input  wire logic                          eoc_event,
	input  wire logic                          compare_a,
	input  wire logic                          compare_b,
	input  wire logic                          compare_c,
	input  wire logic                          duty_write,
	input  wire logic                          phase_write,
	input  wire logic                          cmpa_write,
	input  wire logic                          update_taken,
	input  wire logic [3:0]                    prot_active,
	output logic                               pci_active,
	output logic                               adc_trig1,
	output logic                               adc_trig2,
	output logic                               gen_trigger,
	output logic                               cpu_irq,
	output logic                               update_request
);
	import pwpet_pkg::*;

	// ----------------------------------------
	// registers and bus state
	// ----------------------------------------
	logic [15:0]        pci_high;
	logic [15:0]        evt_low;
	logic [15:0]        evt_high;
	logic [15:0]        config_reg;
	logic [ADDR_W-1:0]  aw_addr;
	logic [DATA_W-1:0]  w_data;
	logic [3:0]         w_strb;
	logic               commit;
	logic               wr_hit;
	logic               wr_pci;
	logic               wr_evl;
	logic               wr_evh;
	logic               wr_sta;
	logic               wr_cfg;
	logic               rd_hit;
	logic [15:0]        rd_word;
	logic [15:0]        status_word;

	function automatic logic [15:0] wmerge(
		input logic [15:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb,
		input logic [15:0] mask
	);
		logic [15:0] lane;
		lane = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
		wmerge = lane & mask;
	endfunction

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// both channels must be held before the write commits
	assign commit = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	assign wr_pci = commit & (aw_addr == OFS_PCI_HIGH);
	assign wr_evl = commit & (aw_addr == OFS_EVT_LOW);
	assign wr_evh = commit & (aw_addr == OFS_EVT_HIGH);
	assign wr_sta = commit & (aw_addr == OFS_STATUS);
	assign wr_cfg = commit & (aw_addr == OFS_CONFIG);
	assign wr_hit = wr_pci | wr_evl | wr_evh | wr_sta | wr_cfg;
	assign rd_hit = (s_axi_araddr == OFS_PCI_HIGH) | (s_axi_araddr == OFS_EVT_LOW) |
		(s_axi_araddr == OFS_EVT_HIGH) | (s_axi_araddr == OFS_STATUS) |
		(s_axi_araddr == OFS_CONFIG);
	assign status_word = {14'h0000, pci_active, update_request};
	assign rd_word = (s_axi_araddr == OFS_PCI_HIGH) ? pci_high :
		(s_axi_araddr == OFS_EVT_LOW) ? evt_low :
		(s_axi_araddr == OFS_EVT_HIGH) ? evt_high :
		(s_axi_araddr == OFS_STATUS) ? status_word :
		(s_axi_araddr == OFS_CONFIG) ? config_reg : 16'h0000;

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_addr       <= 8'h00;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_addr       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
			end
			if (commit) begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
				s_axi_bvalid  <= 1'b1;
				s_axi_bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pci_high   <= RST_PCI_HIGH;
			evt_low    <= RST_EVT_LOW;
			evt_high   <= RST_EVT_HIGH;
			config_reg <= RST_CONFIG;
		end else begin
			if (wr_pci) pci_high <= wmerge(pci_high, w_data, w_strb, MASK_PCI_HIGH);
			if (wr_evl) evt_low <= wmerge(evt_low, w_data, w_strb, MASK_EVT_LOW);
			if (wr_evh) evt_high <= wmerge(evt_high, w_data, w_strb, MASK_EVT_HIGH);
			if (wr_cfg) config_reg <= wmerge(config_reg, w_data, w_strb, MASK_CONFIG);
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {16'h0000, rd_word};
			s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [EXT_W-1:0] ext_raw;
	logic [EXT_W-1:0] ext_f;

	assign ext_raw = {logic_cell_one, comparator_in, pin_in, remap_in};

	genvar i;
	generate
		for (i = 0; i < EXT_W; i++) begin : g_sync
			logic s1;
			logic s2;
			logic s3;
			logic filt;
			// a change counts only once stages two and three agree
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1   <= 1'b0;
					s2   <= 1'b0;
					s3   <= 1'b0;
					filt <= 1'b0;
				end else begin
					s1 <= ext_raw[i];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) filt <= s3;
				end
			end
			assign ext_f[i] = filt;
		end
	endgenerate

	// ----------------------------------------
	// source selection
	// ----------------------------------------
	logic [2:0]  mux_sel;
	logic [4:0]  src_sel;
	logic        gen_mux;
	logic [31:0] src_vec;
	logic        pci_src;

	assign mux_sel = config_reg[POS_MUX +: 3];
	assign src_sel = config_reg[POS_SRC +: 5];
	assign gen_mux = gen_out[mux_sel] & GEN_PRESENT[mux_sel];                // R03
	// index order follows the source code; 4..7 reserved read zero
	assign src_vec = {ext_f[19], ext_f[18:15], other_core_evt, ext_f[14:11],
		ext_f[10:0], 4'h0, combo_trig_b, combo_trig_a, gen_mux, 1'b0};       // R21 R22
	assign pci_src = src_vec[src_sel];                                       // R21 R22

	// ----------------------------------------
	// software bit and qualifiers
	// ----------------------------------------
	logic       sw_bit;
	logic [1:0] sw_mode;
	logic       acc_in;
	logic       acc_qual;
	logic [7:0] tq_vec;
	logic       tq_sel;
	logic       tq_final;
	logic       term_hit;
	logic       local_active;
	logic [2:0] bp_sel;
	logic       bypass_val;
	logic       next_pci_active;

	assign sw_bit   = pci_high[POS_SOFTWARE_PROTECT_BIT];
	assign sw_mode  = pci_high[POS_SWMODE +: 2];
	assign acc_in   = pci_src | ((sw_mode == SWM_ACCEPT) & sw_bit);          // R05 R06
	assign acc_qual = (sw_mode == SWM_AQUAL) ? sw_bit : 1'b1;                // R05 R06
	assign tq_vec   = {1'b0, pci_src9, pci_src8, gen_mux, gen_triggered,
		blanking_active, duty_active, 1'b1};                                 // R09 R10
	assign tq_sel   = tq_vec[pci_high[POS_TERM_QUAL_SOURCE +: 3]];                       // R10
	assign tq_final = (tq_sel ^ pci_high[POS_TERM_QUAL_POLARITY]) |
		((sw_mode == SWM_TQUAL) & sw_bit);                                   // R08 R06
	assign term_hit = term_event & tq_final;

	pwpet_accept u_accept (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.src_in     (acc_in),
		.acc_qual   (acc_qual),
		.term_hit   (term_hit),
		.acceptance_criteria        (pci_high[POS_ACP +: 3]),
		.latch_rdom (pci_high[POS_LATCH_DOMINANCE]),
		.active     (local_active)
	);

	// ----------------------------------------
	// bypass
	// ----------------------------------------
	assign bp_sel     = pci_high[POS_BYPASS_SOURCE_SEL +: 3];
	assign bypass_val = other_gen_pci[bp_sel] & GEN_PRESENT[bp_sel];         // R02 R03
	assign next_pci_active = pci_high[POS_BYPASS_ENABLE] ? bypass_val : local_active; // R01

	// ----------------------------------------
	// adc triggers
	// ----------------------------------------
	logic [2:0] cmp_vec;
	logic       adc1_src;
	logic       adc2_src;
	logic [4:0] ps_val;
	logic [4:0] ofs_val;
	logic [4:0] ps_cnt;
	logic [4:0] ofs_cnt;
	logic       ofs_done;
	logic       adc1_fire;
	logic       cnt_clear;

	assign cmp_vec   = {compare_c, compare_b, compare_a};
	assign adc1_src  = |(cmp_vec & evt_low[POS_EN1 +: 3]);                   // R12
	assign adc2_src  = |(cmp_vec & evt_high[POS_EN2 +: 3]);                  // R13
	assign ps_val    = evt_low[POS_PS +: 5];
	assign ofs_val   = evt_high[POS_OFS +: 5];
	assign ofs_done  = (ofs_cnt == ofs_val);
	assign adc1_fire = adc1_src & ofs_done & (ps_cnt == 5'h00);              // R11 R23
	// a new setting restarts both counts from the next event
	assign cnt_clear = wr_evl | wr_evh;

	always_ff @(posedge aclk) begin
		if (!aresetn || cnt_clear) begin
			ps_cnt  <= 5'h00;
			ofs_cnt <= 5'h00;
		end else if (adc1_src) begin
			if (!ofs_done) begin
				ofs_cnt <= ofs_cnt + 5'h01;                                  // R23
			end else if (ps_cnt == ps_val) begin
				ps_cnt <= 5'h00;                                             // R11
			end else begin
				ps_cnt <= ps_cnt + 5'h01;                                    // R11
			end
		end
	end

	// ----------------------------------------
	// generator trigger, update, interrupt
	// ----------------------------------------
	logic [2:0] trg_sel;
	logic       next_gen_trigger;
	logic [1:0] upd_sel;
	logic       auto_upd;
	logic       sw_upd;
	logic [1:0] iev_sel;
	logic       tb_irq;
	logic [3:0] prot_prev;
	logic [3:0] prot_rise;
	logic       next_irq;

	assign trg_sel = evt_low[POS_TRGSEL +: 3];
	assign next_gen_trigger = (trg_sel == TRG_EOC) ? eoc_event :
		(trg_sel == TRG_CMPA) ? compare_a :
		(trg_sel == TRG_CMPB) ? compare_b :
		(trg_sel == TRG_CMPC) ? compare_c : 1'b0;                            // R16

	assign upd_sel  = evt_low[POS_UPD +: 2];
	assign auto_upd = ((upd_sel == UPD_DUTY) & duty_write) |
		((upd_sel == UPD_PHASE) & phase_write) |
		((upd_sel == UPD_CMPA) & cmpa_write);                                // R14 R15
	assign sw_upd   = wr_sta & w_strb[0] & w_data[POS_UREQ];                 // R15

	assign iev_sel  = evt_high[POS_IEVT +: 2];
	assign tb_irq   = ((iev_sel == IEV_EOC) & eoc_event) |
		((iev_sel == IEV_CMPA) & compare_a) |
		((iev_sel == IEV_ADC1) & adc1_fire);                                 // R19 R20
	assign prot_rise = prot_active & ~prot_prev & evt_high[POS_IEN +: 4];    // R17 R18 R24
	assign next_irq  = tb_irq | (|prot_rise);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pci_active     <= 1'b0;
			adc_trig1      <= 1'b0;
			adc_trig2      <= 1'b0;
			gen_trigger    <= 1'b0;
			cpu_irq        <= 1'b0;
			prot_prev      <= 4'h0;
			update_request <= 1'b0;
		end else begin
			pci_active  <= next_pci_active;
			adc_trig1   <= adc1_fire;
			adc_trig2   <= adc2_src;
			gen_trigger <= next_gen_trigger;
			cpu_irq     <= next_irq;
			prot_prev   <= prot_active;
			// a set in the same cycle as the take wins
			if (auto_upd || sw_upd) begin
				update_request <= 1'b1;                                      // R14
			end else if (update_taken) begin
				update_request <= 1'b0;
			end
		end
	end

endmodule

// ===== tb.sv
// self-checking bench for pwpet_top
// assumes pwpet_far counts far pulses and pwpet_props is bound
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pwpet_pkg::*;
	logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0, logic_cell_one = 0, combo_trig_a = 0;
	logic        combo_trig_b = 0, pci_src8 = 0, pci_src9 = 0, duty_active = 0, term_event = 0;
	logic        blanking_active = 0, gen_triggered = 0, eoc_event = 0, compare_a = 0;
	logic        compare_b = 0, compare_c = 0, duty_write = 0, phase_write = 0, cmpa_write = 0;
	logic        update_taken = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, pci_active, adc_trig1, adc_trig2, gen_trigger, cpu_irq;
	logic        update_request;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_wstrb = 4'hF, pin_in = 0, comparator_in = 0, other_core_evt = 0;
	logic [3:0]  prot_active = 0, pv = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, gen_out = 0, other_gen_pci = 0;
	logic [10:0] remap_in = 0;
	logic [15:0] el = 0, eh = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, w;
	int          errors = 0, cmp_count = 0, n1 = 0, e1 = 0, e2 = 0, ei = 0;
	pwpet_top i_dut (.*);
	pwpet_far i_far (.*);
	always #12.5 aclk = ~aclk;
	// qualifier levels wander; they only matter in latched modes
	always @(posedge aclk)
		{pci_src8, pci_src9, duty_active, blanking_active, gen_triggered, term_event}
			<= 6'($urandom);
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic wnr, input logic [7:0] a, input logic [15:0] d,
		input logic [31:0] e, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {16'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wnr}};
		{s_axi_arvalid, s_axi_rready} <= {2{!wnr}};
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_bready & s_axi_bvalid | s_axi_rready & s_axi_rvalid) begin
				{s_axi_bready, s_axi_rready} <= 2'h0;
				chk(wnr ? s_axi_bresp : s_axi_rresp, r, "resp");
				if (!wnr) chk(s_axi_rdata, e, "rdata");
			end
		end while (s_axi_bready | s_axi_rready);
	endtask
	task automatic step(input logic [3:0] ev, input logic [3:0] pa);
		logic f, t, g, i;
		@(posedge aclk);
		{eoc_event, compare_c, compare_b, compare_a} <= ev;
		prot_active <= pa;
		@(posedge aclk);
		{eoc_event, compare_c, compare_b, compare_a} <= 4'h0;
		f = |(ev[2:0] & el[10:8]) && n1 >= eh[4:0] && (n1 - eh[4:0]) % (el[15:11] + 1) == 0;
		n1 += |(ev[2:0] & el[10:8]);
		t = |(ev[2:0] & eh[7:5]);
		g = el[2:0] == 0 ? ev[3] : el[2:0] < 4 && ev[el[2:0] - 1];
		i = (eh[9:8] == 0 ? ev[3] : eh[9:8] == 1 ? ev[0] : eh[9:8] == 2 && f)
			| (|(pa & ~pv & eh[15:12]));
		pv = pa;
		e1 += f;
		e2 += t;
		ei += i;
		@(negedge aclk);
		chk(adc_trig1, f, "adc_trig1");
		chk(adc_trig2, t, "adc_trig2");
		chk(gen_trigger, g, "gen_trigger");
		chk(cpu_irq, i, "cpu_irq");
	endtask
	task automatic upd(input logic [3:0] p, input logic e);
		@(posedge aclk);
		{update_taken, cmpa_write, phase_write, duty_write} <= p;
		@(posedge aclk);
		{update_taken, cmpa_write, phase_write, duty_write} <= 4'h0;
		repeat (2) @(negedge aclk);
		chk(update_request, e, "update_request");
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		w = $urandom(32'h6B88944C);
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		for (int k = 0; k < 3; k++) begin
			w = $urandom;
			bus(0, 8'(k * 4), 0, 0, RESP_OKAY);
			bus(1, 8'(k * 4), w[15:0], 0, RESP_OKAY);
			bus(0, 8'(k * 4), 0, w[15:0] & (k == 0 ? MASK_PCI_HIGH : k == 1 ? MASK_EVT_LOW
				: MASK_EVT_HIGH), RESP_OKAY);
			bus(1, 8'(k * 4), 0, 0, RESP_OKAY);
		end
		bus(1, 8'h14, 16'hFFFF, 0, RESP_SLVERR);
		bus(0, 8'h14, 0, 0, RESP_SLVERR);
		$display("register map done");
		for (int c = 0; c < 32; c++) begin
			w = $urandom;
			@(posedge aclk);
			{logic_cell_one, comparator_in, other_core_evt, pin_in, remap_in} <= w[31:8];
			{combo_trig_b, combo_trig_a} <= w[3:2];
			gen_out <= w[23:16];
			bus(1, OFS_CONFIG, {5'h0, w[7:5], 3'h0, 5'(c)}, 0, RESP_OKAY);
			// synchronised inputs take four extra cycles
			repeat (10) @(posedge aclk);
			@(negedge aclk);
			chk(pci_active, c == 1 ? w[16 + w[7:5]] : c > 1 && (c < 4 || c > 7) && w[c],
				"pci_source");
		end
		bus(1, OFS_CONFIG, 0, 0, RESP_OKAY);
		for (int k = 0; k < 6; k++) begin
			bus(1, OFS_PCI_HIGH, 16'(k % 2 << 7 | k / 2 << 5 | (k < 4) * 32'h0307),
				0, RESP_OKAY);
			repeat (3) @(negedge aclk);
			chk(pci_active, k > 0 && k < 4, "software_bit");
		end
		for (int k = 0; k < 8; k++) begin
			other_gen_pci <= 8'($urandom);
			bus(1, OFS_PCI_HIGH, 16'(32'h8 + k << 12), 0, RESP_OKAY);
			repeat (3) @(negedge aclk);
			chk(pci_active, other_gen_pci[k], "bypass");
		end
		$display("source selection done");
		for (int c = 0; c < 8; c++) begin
			el = 16'(($urandom % 4) << 11 | $urandom & 32'h0700 | c);
			eh = 16'($urandom & 32'hF0E0 | c % 4 << 8 | $urandom % 4);
			bus(1, OFS_EVT_LOW, el, 0, RESP_OKAY);
			bus(1, OFS_EVT_HIGH, eh, 0, RESP_OKAY);
			n1 = 0;
			repeat (20) step(4'($urandom), 4'($urandom));
		end
		$display("events done");
		for (int u = 0; u < 4; u++) begin
			bus(1, OFS_EVT_LOW, 16'(u << 3), 0, RESP_OKAY);
			for (int j = 0; j < 3; j++) begin
				upd(4'(1 << j), u == j + 1);
				upd(4'h8, 1'h0);
			end
		end
		upd(4'hC, 1'h1);
		upd(4'h8, 1'h0);
		bus(1, OFS_STATUS, 16'h1, 0, RESP_OKAY);
		bus(0, OFS_STATUS, 0, {other_gen_pci[7], 1'h1}, RESP_OKAY);
		upd(4'h8, 1'h0);
		$display("update request done");
		chk(i_far.n1, e1, "adc1_pulses");
		chk(i_far.n2, e2, "adc2_pulses");
		chk(i_far.ni, ei, "irq_pulses");
		final_report;
	end
	// the run needs some 1200 cycles; allow about 8000
	initial begin
		#200us;
		errors++;
		final_report;
	end
endmodule
